// ---- rtl/line_coder_defines.vh ----
// Behaviour
// - twelve-frame mode: odd-frame framing bits carry terminal pattern, even frames signaling
// - terminal framing bits in frames 1,3,5,7,9,11 are 1,0,1,0,1,0
// - signaling framing bits in frames 2,4,6,8,10,12 are 0,0,1,1,1,0
// - frame 12 signaling framing bit may carry yellow alarm instead
// - twenty-four-frame mode shares framing bit: alignment, data link, check bits
// - alignment bits in frames 4,8,12,16,20,24 are 0,0,1,0,1,1
// - odd frames carry data link bit taken from transmit link input
// - check bits in frames 2,6,...,22 computed internally when source select 0
// - source select 1: check bits sampled from serial input at framing bit
// - twelve-frame mode: bit 8 carries A in frame 6, B in frame 12
// - twenty-four-frame mode: A,B,C,D in frames 6,12,18,24
// - clear channels keep bit 8 as data in signaling frames
// - alternate mark inversion: marks alternate polarity, zeros send nothing
// - bit-7 suppression forces bit 7 of all-zero channel to one
// - substitution enabled: every eight outgoing zeros become substitution word
// - word is 000+-0-+ after positive mark, 000-+0+- after negative
// - error monitor ignores violations at positions four and seven of word when substitution enabled
// - receiver restores each substitution word to eight zeros when enabled
// - substitution words always flagged in status regardless of enable
// - frame is one framing bit then 24 eight-bit timeslots
// - channel data goes most significant bit first
// - superframe spans 12 or 24 frames by mode
`ifndef LINE_CODER_DEFINES_VH
`define LINE_CODER_DEFINES_VH
`define BITS_PER_FRAME 8'd193
`define FRAMES_12 5'd12
`define FRAMES_24 5'd24
`define TS_PATTERN 12'h111
`define SF_PATTERN 12'h2a0
`define APS_PATTERN 6'h34
`define RX_DELAY 4'd8
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_CLEAR_LO 8'h08
`define REG_SIGNAL 8'h0c
`define CTRL_RESET 8'h00
`define CTRL_MODE24 0
`define CTRL_CRC_EXT 1
`define CTRL_ZCS 2
`define CTRL_SUBST 3
`define CTRL_YEL 4
`endif

// ---- rtl/crc6_gen.v ----
`timescale 1ns/10ps
`include "line_coder_defines.vh"
// ==========================================
// check-bit generator, x^6+x+1 over payload
module crc6_gen (
    input wire ref_clk_in, // clock
    input wire reset_in, // sync reset
    input wire start_in, // superframe start, latches result
    input wire bit_valid_in, // payload bit strobe
    input wire bit_in, // payload bit
    output reg [5:0] crc_out // last superframe result
);
    reg [5:0] acc_q;
    wire fb = bit_in ^ acc_q[5];
    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            acc_q <= 6'h00;
            crc_out <= 6'h00;
        end else if (start_in) begin
            crc_out <= acc_q;
            acc_q <= 6'h00;
        end else if (bit_valid_in) begin
            acc_q <= {acc_q[4:0], 1'b0} ^ {4'h0, fb, fb};
        end
    end
endmodule

// ---- rtl/rx_decoder.v ----
`timescale 1ns/10ps
`include "line_coder_defines.vh"
// ==========================================
// receive bipolar decoder with substitution detect
module rx_decoder (
    input wire ref_clk_in, // clock
    input wire reset_in, // sync reset
    input wire subst_en_in, // substitution enable
    input wire pos_in, // synchronised positive pulse
    input wire neg_in, // synchronised negative pulse
    input wire bit_tick_in, // line bit time
    output reg data_out, // decoded data, 8 ticks late
    output reg bpv_out, // unexcused violation
    output reg subst_seen_out // substitution word seen
);
    reg [7:0] p_q;
    reg [7:0] n_q;
    reg last_pos_q;
    // judged as it leaves, so a completed word is cleared first
    wire mark = p_q[7] | n_q[7];
    // oldest at bit 7; word pattern in arrival order
    wire word_hit = (p_q == 8'h00 && n_q == 8'h00) ? 1'b0 :
        ((p_q[7:5] == 3'b000) && (n_q[7:5] == 3'b000) &&
         (p_q[2] == 1'b0) && (n_q[2] == 1'b0) &&
         (({p_q[4],n_q[3],n_q[1],p_q[0]} == 4'hf) ||
          ({n_q[4],p_q[3],p_q[1],n_q[0]} == 4'hf)) &&
         ((p_q[4:0] | n_q[4:0]) == 5'h1b));
    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            p_q <= 8'h00;
            n_q <= 8'h00;
            last_pos_q <= 1'b0;
            data_out <= 1'b0;
            bpv_out <= 1'b0;
            subst_seen_out <= 1'b0;
        end else if (bit_tick_in) begin
            subst_seen_out <= word_hit;
            if (word_hit && subst_en_in) begin
                p_q <= {7'h00, pos_in};
                n_q <= {7'h00, neg_in};
                data_out <= p_q[7] | n_q[7];
                bpv_out <= 1'b0;
            end else begin
                p_q <= {p_q[6:0], pos_in};
                n_q <= {n_q[6:0], neg_in};
                data_out <= p_q[7] | n_q[7];
                bpv_out <= mark & (p_q[7] == last_pos_q);
            end
            if (mark)
                last_pos_q <= p_q[7];
        end else begin
            subst_seen_out <= 1'b0;
            bpv_out <= 1'b0;
        end
    end
endmodule

// ---- rtl/t1_superframe_line_coder.v ----
`timescale 1ns/10ps
`include "line_coder_defines.vh"
module t1_superframe_line_coder (
    input wire ref_clk_in, // clock
    input wire reset_in, // sync reset, active high
    input wire tx_bit_tick_in, // transmit bit time, same domain
    input wire transmit_serial_data_input_in, // tx payload
    input wire transmit_link_input_in, // data link bit
    input wire [3:0] abcd_in, // signaling bits a,b,c,d
    input wire rpos_in, // line positive pulse pin
    input wire rneg_in, // line negative pulse pin
    input wire rx_bit_tick_in, // receive bit time, same domain
    output reg tpos_out, // line positive pulse
    output reg tneg_out, // line negative pulse
    output reg transmit_multiframe_out, // superframe start
    output reg transmit_signaling_frame_out, // signaling frame flag
    output reg transmit_signaling_select_out, // c/d half flag, b half in twelve-frame mode
    output reg rx_data_out, // decoded receive data
    output reg rx_bpv_out, // violation pulse
    output reg [7:0] tx_frame_out, // current frame, 1 based
    input wire s_awvalid, // axi
    output wire s_awready, // axi
    input wire [31:0] s_awaddr, // axi
    input wire s_wvalid, // axi
    output wire s_wready, // axi
    input wire [31:0] s_wdata, // axi
    input wire [3:0] s_wstrb, // axi
    output reg s_bvalid, // axi
    input wire s_bready, // axi
    output reg [1:0] s_bresp, // axi
    input wire s_arvalid, // axi
    output wire s_arready, // axi
    input wire [31:0] s_araddr, // axi
    output reg s_rvalid, // axi
    input wire s_rready, // axi
    output reg [31:0] s_rdata, // axi
    output reg [1:0] s_rresp // axi
);
    // ==========================================
    // registers
    reg [7:0] ctrl_q;
    reg [23:0] clear_q;
    reg status_subst_q;
    reg status_bpv_q;
    reg aw_q, w_q;
    reg [31:0] awaddr_q, wdata_q;
    reg [3:0] wstrb_q;
    wire mode24 = ctrl_q[`CTRL_MODE24];
    assign s_awready = ~aw_q & ~s_bvalid;
    assign s_wready = ~w_q & ~s_bvalid;
    assign s_arready = ~s_rvalid;
    wire rx_subst;
    wire wr_go = aw_q & w_q & ~s_bvalid;
    wire wr_status = wr_go && awaddr_q[7:0] == `REG_STATUS;
    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 32'h0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            s_bvalid <= 1'b0;
            s_bresp <= 2'b00;
            ctrl_q <= `CTRL_RESET;
            clear_q <= 24'h0;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_q <= 1'b1;
                awaddr_q <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_q <= 1'b1;
                wdata_q <= s_wdata;
                wstrb_q <= s_wstrb;
            end
            if (wr_go) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp <= 2'b00;
                case (awaddr_q[7:0])
                    `REG_CTRL: begin
                        if (wstrb_q[0])
                            ctrl_q <= wdata_q[7:0];
                    end
                    `REG_CLEAR_LO: begin
                        if (wstrb_q[0])
                            clear_q[7:0] <= wdata_q[7:0];
                        if (wstrb_q[1])
                            clear_q[15:8] <= wdata_q[15:8];
                        if (wstrb_q[2])
                            clear_q[23:16] <= wdata_q[23:16];
                    end
                    `REG_STATUS: ;
                    default: s_bresp <= 2'b10;
                endcase
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end
    // sticky status, write-one-to-clear, set wins
    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            status_subst_q <= 1'b0;
            status_bpv_q <= 1'b0;
        end else begin
            status_subst_q <= rx_subst |
                (status_subst_q & ~(wr_status & wstrb_q[0] & wdata_q[0]));
            status_bpv_q <= rx_bpv_out |
                (status_bpv_q & ~(wr_status & wstrb_q[0] & wdata_q[1]));
        end
    end
    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            s_rvalid <= 1'b0;
            s_rdata <= 32'h0;
            s_rresp <= 2'b00;
        end else if (s_arvalid && s_arready) begin
            s_rvalid <= 1'b1;
            s_rresp <= 2'b00;
            case (s_araddr[7:0])
                `REG_CTRL: s_rdata <= {24'h0, ctrl_q};
                `REG_STATUS: s_rdata <= {30'h0, status_bpv_q,
                    status_subst_q};
                `REG_CLEAR_LO: s_rdata <= {8'h0, clear_q};
                `REG_SIGNAL: s_rdata <= {19'h0, tx_frame_out, 5'h0};
                default: begin
                    s_rdata <= 32'h0;
                    s_rresp <= 2'b10;
                end
            endcase
        end else if (s_rvalid && s_rready) begin
            s_rvalid <= 1'b0;
        end
    end
    // ==========================================
    // transmit counters
    reg [7:0] bit_q;
    reg [4:0] frame_q;
    reg [7:0] chan_q;
    wire [4:0] frames = mode24 ? `FRAMES_24 : `FRAMES_12;
    wire fbit = (bit_q == 8'd0);
    wire [7:0] slot_w = (bit_q - 8'd1) >> 3;
    wire [4:0] slot = slot_w[4:0];
    wire [2:0] pos = bit_q[2:0] - 3'd1;
    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            bit_q <= 8'd0;
            frame_q <= 5'd0;
        end else if (tx_bit_tick_in) begin
            if (bit_q == `BITS_PER_FRAME - 8'd1) begin
                bit_q <= 8'd0;
                frame_q <= (frame_q == frames - 5'd1) ? 5'd0 :
                    frame_q + 5'd1;
            end else begin
                bit_q <= bit_q + 8'd1;
            end
        end
    end
    // ==========================================
    // framing and signaling bit select
    wire [5:0] crc;
    reg [5:0] crc_ext_q;
    wire sig_frame = (frame_q % 5'd6) == 5'd5;
    wire [11:0] ts_pat = `TS_PATTERN;
    wire [11:0] sf_pat = `SF_PATTERN;
    wire [5:0] aps_pat = `APS_PATTERN;
    reg tx_bit;
    always @* begin
        tx_bit = transmit_serial_data_input_in;
        if (fbit) begin
            if (!mode24) begin
                if (!frame_q[0])
                    tx_bit = ts_pat[frame_q[3:0]];
                else if (frame_q == 5'd11 && ctrl_q[`CTRL_YEL])
                    tx_bit = 1'b1;
                else
                    tx_bit = sf_pat[frame_q[3:0]];
            end else if (!frame_q[0]) begin
                tx_bit = transmit_link_input_in;
            end else if (frame_q[1:0] == 2'd3) begin
                tx_bit = aps_pat[frame_q[4:2]];
            end else begin
                tx_bit = ctrl_q[`CTRL_CRC_EXT] ? transmit_serial_data_input_in :
                    crc[5 - (frame_q >> 2)];
            end
        end else if (sig_frame && pos == 3'd7 && !clear_q[slot]) begin
            tx_bit = abcd_in[3 - ((frame_q + 5'd1) / 5'd6 - 5'd1)];
        end
    end
    crc6_gen u_crc (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .start_in(tx_bit_tick_in && fbit && frame_q == 5'd0 && mode24),
        .bit_valid_in(tx_bit_tick_in && !fbit),
        .bit_in(transmit_serial_data_input_in),
        .crc_out(crc)
    );
    // ==========================================
    // zero suppression and bipolar coding
    reg [7:0] octet_q;
    reg [7:0] pend_q;
    reg [3:0] sub_q;
    reg last_pos_q;
    wire zero_octet_early = (octet_q[5:0] == 6'h0) && !tx_bit &&
        !transmit_serial_data_input_in;
    wire stuffed = ctrl_q[`CTRL_ZCS] && !fbit && pos == 3'd6 &&
        zero_octet_early;
    wire out_bit = tx_bit | stuffed;
    // eight bits held back so a whole zero run can be swapped out
    wire sub_start = ctrl_q[`CTRL_SUBST] && sub_q == 4'd0 &&
        pend_q == 8'h00;
    wire [3:0] sub_pos = sub_start ? 4'd1 : sub_q;
    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            octet_q <= 8'h0;
            pend_q <= 8'h0;
            sub_q <= 4'h0;
            last_pos_q <= 1'b0;
            tpos_out <= 1'b0;
            tneg_out <= 1'b0;
        end else if (tx_bit_tick_in) begin
            octet_q <= {octet_q[6:0], out_bit};
            pend_q <= {pend_q[6:0], out_bit};
            sub_q <= (sub_pos == 4'd0 || sub_pos == 4'd8) ? 4'd0 :
                sub_pos + 4'd1;
            tpos_out <= 1'b0;
            tneg_out <= 1'b0;
            if (sub_pos != 4'd0) begin
                // violations at 4 and 7, reference kept
                if (sub_pos == 4'd4 || sub_pos == 4'd8) begin
                    tpos_out <= last_pos_q;
                    tneg_out <= ~last_pos_q;
                end else if (sub_pos == 4'd5 || sub_pos == 4'd7) begin
                    tpos_out <= ~last_pos_q;
                    tneg_out <= last_pos_q;
                end
            end else if (pend_q[7]) begin
                tpos_out <= ~last_pos_q;
                tneg_out <= last_pos_q;
                last_pos_q <= ~last_pos_q;
            end
        end
    end
    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            transmit_multiframe_out <= 1'b0;
            transmit_signaling_frame_out <= 1'b0;
            transmit_signaling_select_out <= 1'b0;
            tx_frame_out <= 8'h0;
        end else begin
            transmit_multiframe_out <= frame_q == 5'd0;
            transmit_signaling_frame_out <= sig_frame;
            transmit_signaling_select_out <= frame_q >= (frames >> 1);
            tx_frame_out <= {3'h0, frame_q} + 8'd1;
        end
    end
    // ==========================================
    // receive path, pins synchronised first
    reg [1:0] rp_q, rn_q;
    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            rp_q <= 2'b00;
            rn_q <= 2'b00;
        end else begin
            rp_q <= {rp_q[0], rpos_in};
            rn_q <= {rn_q[0], rneg_in};
        end
    end
    wire rx_d, rx_v;
    rx_decoder u_rx (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .subst_en_in(ctrl_q[`CTRL_SUBST]),
        .pos_in(rp_q[1]),
        .neg_in(rn_q[1]),
        .bit_tick_in(rx_bit_tick_in),
        .data_out(rx_d),
        .bpv_out(rx_v),
        .subst_seen_out(rx_subst)
    );
    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            rx_data_out <= 1'b0;
            rx_bpv_out <= 1'b0;
        end else begin
            rx_data_out <= rx_d;
            rx_bpv_out <= rx_v;
        end
    end
endmodule

// ---- dv/line_coder_props.sv ----
`timescale 1ns/10ps
// ==========
// port checks for the line coder
module line_coder_props (
    input wire ref_clk_in, // clock
    input wire reset_in, // sync reset
    input wire tx_bit_tick_in, // tx bit time
    input wire tpos_out, // pos pulse
    input wire tneg_out, // neg pulse
    input wire [7:0] tx_frame_out, // frame
    input wire s_arvalid, // axi
    input wire s_arready, // axi
    input wire s_bvalid, // axi
    input wire s_bready, // axi
    input wire s_rvalid, // axi
    input wire s_rready, // axi
    input wire [31:0] s_rdata, // axi
    input wire [1:0] s_rresp // axi
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    reg [8:0] len_q;
    reg seen_q;
    // ticks since the last frame step, counting any tick in the cycle the step is seen
    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            len_q <= 9'h0;
            seen_q <= 1'b0;
        end else if ($changed(tx_frame_out)) begin
            len_q <= {8'h0, tx_bit_tick_in};
            seen_q <= 1'b1;
        end else if (tx_bit_tick_in) begin
            len_q <= len_q + 9'h1;
        end
    end
    chk_ami_one_polarity: assert property (!(tpos_out && tneg_out))
        else $error("both pulse lines high");
    chk_pulse_on_tick: assert property (
        ($changed(tpos_out) || $changed(tneg_out)) |-> $past(tx_bit_tick_in))
        else $error("line pulse moved off a bit time");
    chk_frame_range: assert property (tx_frame_out <= 8'h18)
        else $error("frame number above 24");
    chk_frame_step: assert property ($changed(tx_frame_out) |->
        tx_frame_out == 8'h01 || tx_frame_out == $past(tx_frame_out) + 8'h01)
        else $error("frame number skipped");
    chk_frame_length: assert property (
        $changed(tx_frame_out) && seen_q |-> len_q == 9'h0c1)
        else $error("frame not 193 bits long");
    chk_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
        else $error("read answer late");
    chk_write_close: assert property (s_bvalid && s_bready |=> !s_bvalid)
        else $error("write response repeated");
    chk_read_close: assert property (s_rvalid && s_rready |=> !s_rvalid)
        else $error("read response repeated");
    chk_err_zero_data: assert property (
        s_rvalid && s_rresp == 2'h2 |-> s_rdata == 32'h0)
        else $error("error read carries data");
    cover property (tpos_out);
    cover property (tx_frame_out == 8'h18);
    cover property (s_rvalid && s_rresp == 2'h2);
endmodule
bind t1_superframe_line_coder line_coder_props i_props (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .tx_bit_tick_in(tx_bit_tick_in), .tpos_out(tpos_out),
    .tneg_out(tneg_out), .tx_frame_out(tx_frame_out),
    .s_arvalid(s_arvalid), .s_arready(s_arready), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .s_rdata(s_rdata), .s_rresp(s_rresp));

// ---- dv/t1_line_partner.sv ----
`timescale 1ns/10ps
// ==========
// line interface: span looped back, one cycle of cable delay
module t1_line_partner (
    input wire ref_clk_in, // clock
    input wire tpos_in, // pos pulse from coder
    input wire tneg_in, // neg pulse from coder
    output reg rpos_out, // pos pulse to coder
    output reg rneg_out // neg pulse to coder
);
    initial begin
        rpos_out = 1'b0;
        rneg_out = 1'b0;
    end
    always @(posedge ref_clk_in) begin
        rpos_out <= tpos_in;
        rneg_out <= tneg_in;
    end
endmodule

// ---- dv/t1_superframe_format_line_coder_tb_top.sv ----
`timescale 1ns/10ps
`define CHK(a, e) begin checks = checks + 1; if ((a) !== (e)) begin \
 n_fail = n_fail + 1; \
 $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module t1_superframe_format_line_coder_tb_top;
    reg clk = 1'b0, rst = 1'b1, tick = 1'b0, transmit_serial_data_input = 1'b0, link = 1'b0;
    reg [3:0] abcd = 4'h0, wstrb = 4'hf;
    reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    reg arvalid = 1'b0, rready = 1'b0;
    reg [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
    wire rpos, rneg, tpos_out, tneg_out, rx_data_out, rx_bpv_out;
    wire s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    wire mf_out, sf_out;
    wire [1:0] s_bresp, s_rresp;
    wire [31:0] s_rdata;
    integer n_fail = 0, checks = 0, bpv_n = 0, mf_n = 0, sf_n = 0;
    t1_superframe_line_coder i_dut (.ref_clk_in(clk), .reset_in(rst),
        .tx_bit_tick_in(tick), .transmit_serial_data_input_in(transmit_serial_data_input),
        .transmit_link_input_in(link), .abcd_in(abcd), .rpos_in(rpos),
        .rneg_in(rneg), .rx_bit_tick_in(tick), .tpos_out(tpos_out),
        .tneg_out(tneg_out), .transmit_multiframe_out(mf_out),
        .transmit_signaling_frame_out(sf_out),
        .transmit_signaling_select_out(),
        .rx_data_out(rx_data_out), .rx_bpv_out(rx_bpv_out),
        .tx_frame_out(), .s_awvalid(awvalid), .s_awready(s_awready),
        .s_awaddr(awaddr), .s_wvalid(wvalid), .s_wready(s_wready),
        .s_wdata(wdata), .s_wstrb(wstrb), .s_bvalid(s_bvalid),
        .s_bready(bready), .s_bresp(s_bresp), .s_arvalid(arvalid),
        .s_arready(s_arready), .s_araddr(araddr), .s_rvalid(s_rvalid),
        .s_rready(rready), .s_rdata(s_rdata), .s_rresp(s_rresp));
    t1_line_partner i_line (.ref_clk_in(clk), .tpos_in(tpos_out),
        .tneg_in(tneg_out), .rpos_out(rpos), .rneg_out(rneg));
    initial forever #50 clk = ~clk;
    always @(posedge clk) tick <= rst ? 1'b0 : ~tick;
    // one-cycle pulses would slip past the per-bit sampling
    always @(negedge clk) if (rx_bpv_out) bpv_n = bpv_n + 1;
    task print_verdict;
        begin
            $display("checks=%0d n_fail=%0d", checks, n_fail);
            if (n_fail == 0 && checks > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask
    task wr(input [31:0] a, input [31:0] d, input [1:0] er);
        reg [1:0] r;
        reg at, wt, bt;
        integer n;
        begin
            @(posedge clk);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            bt = 1'b0;
            for (n = 0; n < 64 && !bt; n = n + 1) begin
                @(negedge clk);
                at = awvalid && s_awready;
                wt = wvalid && s_wready;
                bt = s_bvalid;
                r = s_bresp;
                @(posedge clk);
                if (at) awvalid <= 1'b0;
                if (wt) wvalid <= 1'b0;
            end
            bready <= 1'b0;
            if (!bt) begin
                n_fail = n_fail + 1;
                print_verdict;
            end else
                `CHK(r, er)
        end
    endtask
    task rd(input [31:0] a, input [31:0] ed, input [1:0] er);
        reg [1:0] r;
        reg [31:0] d;
        reg at, rt;
        integer n;
        begin
            @(posedge clk);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            rt = 1'b0;
            for (n = 0; n < 64 && !rt; n = n + 1) begin
                @(negedge clk);
                at = arvalid && s_arready;
                rt = s_rvalid;
                r = s_rresp;
                d = s_rdata;
                @(posedge clk);
                if (at) arvalid <= 1'b0;
            end
            rready <= 1'b0;
            if (!rt) begin
                n_fail = n_fail + 1;
                print_verdict;
            end else begin
                `CHK(r, er)
                `CHK(d, ed)
            end
        end
    endtask
    // one sample per bit, taken while the tick edge is still ahead
    task count(input integer bits, output integer m, output integer mx,
               output integer x, output integer v);
        reg lastp;
        integer run, i;
        begin
            m = 0; mx = 0; x = 0; v = 0; run = 0; lastp = 1'b0; i = 0;
            mf_n = 0;
            sf_n = 0;
            while (i < bits) begin
                @(negedge clk);
                if (tick) begin
                    i = i + 1;
                    if (mf_out === 1'b1) mf_n = mf_n + 1;
                    if (sf_out === 1'b1) sf_n = sf_n + 1;
                    if ((tpos_out | tneg_out) === 1'b1) begin
                        if (m > 0 && tpos_out == lastp) v = v + 1;
                        lastp = tpos_out;
                        m = m + 1;
                        run = 0;
                    end else begin
                        run = run + 1;
                        if (run > mx) mx = run;
                    end
                    if (rx_data_out === 1'b1) x = x + 1;
                end
            end
        end
    endtask
    task cfg(input [31:0] c, input [31:0] k, input [3:0] s, input l);
        integer m, mx, x, v;
        begin
            abcd <= s;
            link <= l;
            wr(32'h0, c, 2'h0);
            wr(32'h8, k, 2'h0);
            count(193, m, mx, x, v);
            bpv_n = 0;
        end
    endtask
    task fcase(input [31:0] c, input [31:0] k, input [3:0] s, input l,
               input integer fr, input integer e);
        integer m, mx, x, v;
        begin
            cfg(c, k, s, l);
            count(fr * 193, m, mx, x, v);
            `CHK(m, e)
            `CHK(v, 0)
            `CHK(mf_n, 193)
            `CHK(sf_n, fr / 6 * 193)
        end
    endtask
    task sc_regs;
        begin
            rd(32'h0, 32'h0, 2'h0);
            rd(32'h10, 32'h0, 2'h2);
            wr(32'h10, 32'h1, 2'h2);
            wr(32'h8, 32'h00a5a5a5, 2'h0);
            rd(32'h8, 32'h00a5a5a5, 2'h0);
        end
    endtask
    task sc_frame12;
        begin
            fcase(32'h0, 32'h0, 4'h0, 1'b0, 12, 6);
            fcase(32'h0, 32'h0, 4'hf, 1'b0, 12, 54);
            fcase(32'h0, 32'hffffff, 4'hf, 1'b0, 12, 6);
            fcase(32'h4, 32'h0, 4'h0, 1'b0, 12, 294);
        end
    endtask
    task sc_b8zs;
        integer m, mx, x, v;
        begin
            cfg(32'h8, 32'h0, 4'h0, 1'b0);
            count(12 * 193, m, mx, x, v);
            `CHK(mx < 8, 1'b1)
            `CHK(v > 0, 1'b1)
            `CHK(x, 6)
            `CHK(bpv_n, 0)
            rd(32'h4, 32'h1, 2'h0);
        end
    endtask
    task sc_frame24;
        begin
            fcase(32'h3, 32'h0, 4'h0, 1'b1, 24, 15);
            fcase(32'h3, 32'h0, 4'hf, 1'b0, 24, 99);
        end
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        sc_regs;
        sc_frame12;
        sc_b8zs;
        sc_frame24;
        print_verdict;
    end
endmodule
